//--- design/sps_scaling.sv
// Position scaling path: mask, invert, scale, shift, reverse, rate.
// Assumes raw_data and raw_valid come from the serial receiver on pclk.
//
// Design decisions made here: the address map and register access over APB.
module sps_scaling
  import sps_pkg::*;
#(
  parameter int MS_CYC = MS_CYCLES
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [31:0] raw_data,
  input  wire logic        raw_valid,
  output logic      [31:0] position,
  output logic      [31:0] rate,
  output logic             irq
);

  // ***************************************************************
  // Bus decode
  // ***************************************************************
  logic        acc;
  logic        wr;
  logic        mapped;
  logic [31:0] rd_mux;

  logic [14:0]     scale_num;
  logic [14:0]     scale_den;
  logic [31:0]     preset_val;
  logic [5:0]      nbits;
  logic [9:0]      rate_ms;
  logic            dir_neg;
  logic            logic_neg;
  logic            preset_go;
  logic [ST_W-1:0] stat;
  logic [ST_W-1:0] mask;
  logic [39:0]     zero_shift;
  logic [31:0]     raw_q;
  logic            raw_pend;
  logic [31:0]     scaled;

  assign acc = psel && penable && pready;
  assign wr  = acc && pwrite;

  always_comb begin
    mapped = 1'b1;
    rd_mux = 32'h0000_0000;
    unique case (paddr)
      ADDR_CTRL:   rd_mux = {30'h0, logic_neg, dir_neg};
      ADDR_NUM:    rd_mux = {17'h0, scale_num};
      ADDR_DEN:    rd_mux = {17'h0, scale_den};
      ADDR_PRESET: rd_mux = preset_val;
      ADDR_NBITS:  rd_mux = {26'h0, nbits};
      ADDR_RATEMS: rd_mux = {22'h0, rate_ms};
      ADDR_POS:    rd_mux = position;
      ADDR_RATE:   rd_mux = rate;
      ADDR_SHIFT:  rd_mux = zero_shift[31:0];
      ADDR_STAT:   rd_mux = {28'h0, stat};
      ADDR_MASK:   rd_mux = {28'h0, mask};
      ADDR_RAW:    rd_mux = raw_q;
      default:     mapped = 1'b0;
    endcase
  end

  // One wait state so that every bus output comes from a flip-flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && penable && !pready;
      prdata  <= rd_mux;
      pslverr <= psel && penable && !pready && !mapped;
    end
  end

  // ***************************************************************
  // Parameter registers
  // ***************************************************************
  logic        num_ok;
  logic        den_ok;
  logic        nbits_ok;
  logic        ms_ok;
  logic        preset_ok;
  logic [31:0] neg_max;

  assign neg_max   = 32'h0 - PRESET_MAX;
  // Each ratio change is checked against the other half of the pair
  assign num_ok    = pwdata[31:15] == '0 && pwdata[14:0] != '0 &&
                     pwdata[14:0] <= scale_den;
  assign den_ok    = pwdata[31:15] == '0 && pwdata[14:0] != '0 &&
                     pwdata[14:0] >= scale_num;
  assign nbits_ok  = pwdata[31:6] == '0 && pwdata[5:0] != '0 &&
                     pwdata[5:0] <= NBITS_MAX;
  assign ms_ok     = pwdata[31:10] == '0 && pwdata[9:0] != '0 &&
                     pwdata[9:0] <= RATEMS_MAX;
  assign preset_ok = $signed(pwdata) <= $signed(PRESET_MAX) &&
                     $signed(pwdata) >= $signed(neg_max);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scale_num <= SCALE_RST;
      scale_den <= SCALE_RST;
    end else if (wr && paddr == ADDR_NUM && num_ok) begin
      scale_num <= pwdata[14:0];
    end else if (wr && paddr == ADDR_DEN && den_ok) begin
      scale_den <= pwdata[14:0];
    end
  end

  // Storing the preset touches neither position nor shift
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      preset_val <= PRESET_RST;
    end else if (wr && paddr == ADDR_PRESET && preset_ok) begin
      preset_val <= pwdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nbits   <= NBITS_RST;
      rate_ms <= RATEMS_RST;
    end else if (wr && paddr == ADDR_NBITS && nbits_ok) begin
      nbits <= pwdata[5:0];
    end else if (wr && paddr == ADDR_RATEMS && ms_ok) begin
      rate_ms <= pwdata[9:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dir_neg   <= 1'b0;
      logic_neg <= 1'b0;
      preset_go <= 1'b0;
    end else begin
      preset_go <= wr && paddr == ADDR_CTRL && pwdata[CTRL_PRESET];
      if (wr && paddr == ADDR_CTRL) begin
        dir_neg   <= pwdata[CTRL_DIR_NEG];
        logic_neg <= pwdata[CTRL_LOGIC_NEG];
      end
    end
  end

  // ***************************************************************
  // Extraction and scaling
  // ***************************************************************
  logic [32:0] pow2;
  logic [31:0] bits_mask;
  logic        s_start;
  logic        s_busy;
  logic        s_done;
  logic [47:0] s_quot;
  logic [47:0] s_num;
  logic [31:0] next_scaled;

  assign pow2      = 33'h1 << nbits;
  assign bits_mask = 32'(pow2 - 33'h1);
  assign s_start   = raw_pend && !s_busy;
  assign s_num     = {16'h0000, raw_q} * {33'h0, scale_num};

  // Only the newest sample is kept while the divider is busy
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      raw_q    <= 32'h0000_0000;
      raw_pend <= 1'b0;
    end else if (raw_valid) begin
      raw_q    <= logic_neg ? (raw_data & bits_mask) ^ bits_mask
                            : raw_data & bits_mask;
      raw_pend <= 1'b1;
    end else if (s_start) begin
      raw_pend <= 1'b0;
    end
  end

  sps_div #(.NW(48), .DW(16)) u_scale_div (
    .pclk    (pclk),
    .presetn (presetn),
    .start   (s_start),
    .num     (s_num),
    .den     ({1'b0, scale_den}),
    .busy    (s_busy),
    .done    (s_done),
    .quot    (s_quot)
  );

  // Ratio <= 1 keeps the quotient inside the raw width
  assign next_scaled = s_done ? s_quot[31:0] : scaled;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scaled <= 32'h0000_0000;
    end else begin
      scaled <= next_scaled;
    end
  end

  // ***************************************************************
  // Zero shift, direction and position
  // ***************************************************************
  logic [39:0] sum;
  logic [39:0] next_pos;
  logic [39:0] psv;

  assign psv      = {{8{preset_val[31]}}, preset_val};
  assign sum      = {8'h00, scaled} + zero_shift;
  assign next_pos = dir_neg ? {7'h00, pow2} - sum : sum;

  // Shift is solved against the sample that lands in the same edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      zero_shift <= 40'h00_0000_0000;
    end else if (preset_go) begin
      zero_shift <= dir_neg ? {7'h00, pow2} - psv - {8'h00, next_scaled}
                            : psv - {8'h00, next_scaled};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      position <= 32'h0000_0000;
    end else begin
      position <= next_pos[31:0];
    end
  end

  // ***************************************************************
  // Rate of change
  // ***************************************************************
  logic [16:0] ms_cnt;
  logic        ms_tick;
  logic [9:0]  iv_cnt;
  logic        r_start;
  logic        r_busy;
  logic        r_done;
  logic [47:0] r_quot;
  logic [32:0] diff;
  logic [32:0] mag;
  logic [31:0] last_pos;
  logic        r_neg;

  assign ms_tick = ms_cnt == 17'(MS_CYC - 1);
  assign r_start = ms_tick && iv_cnt == rate_ms - 10'h001 && !r_busy;
  assign diff    = {position[31], position} - {last_pos[31], last_pos};
  assign mag     = diff[32] ? 33'h0 - diff : diff;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ms_cnt <= '0;
      iv_cnt <= '0;
    end else begin
      ms_cnt <= ms_tick ? '0 : ms_cnt + 17'h1;
      if (ms_tick) begin
        iv_cnt <= iv_cnt >= rate_ms - 10'h001 ? '0 : iv_cnt + 10'h001;
      end
    end
  end

  // Difference over the interval, times 1000 ms, over interval ms
  sps_div #(.NW(48), .DW(16)) u_rate_div (
    .pclk    (pclk),
    .presetn (presetn),
    .start   (r_start),
    .num     ({15'h0000, mag} * 48'(MS_PER_SEC)),
    .den     ({6'h00, rate_ms}),
    .busy    (r_busy),
    .done    (r_done),
    .quot    (r_quot)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_pos <= 32'h0000_0000;
      r_neg    <= 1'b0;
      rate     <= 32'h0000_0000;
    end else begin
      if (r_start) begin
        last_pos <= position;
        r_neg    <= diff[32];
      end
      if (r_done) begin
        rate <= r_neg ? 32'h0 - r_quot[31:0] : r_quot[31:0];
      end
    end
  end

  // ***************************************************************
  // Interrupts
  // ***************************************************************
  logic [ST_W-1:0] ev;
  logic [ST_W-1:0] clr;

  always_comb begin
    ev                 = '0;
    ev[ST_PRESET_ERR]  = wr && paddr == ADDR_PRESET && !preset_ok;
    ev[ST_RATE_UPD]    = r_done;
    ev[ST_PARAM_ERR]   = wr && ((paddr == ADDR_NUM && !num_ok) ||
                         (paddr == ADDR_DEN && !den_ok) ||
                         (paddr == ADDR_NBITS && !nbits_ok) ||
                         (paddr == ADDR_RATEMS && !ms_ok));
    ev[ST_PRESET_DONE] = preset_go;
  end

  assign clr = (wr && paddr == ADDR_STAT) ? pwdata[ST_W-1:0] : '0;

  // A set in the clearing cycle survives the clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat <= '0;
      mask <= '0;
      irq  <= 1'b0;
    end else begin
      stat <= (stat & ~clr) | ev;
      irq  <= |(((stat & ~clr) | ev) & mask);
      if (wr && paddr == ADDR_MASK) begin
        mask <= pwdata[ST_W-1:0];
      end
    end
  end

  // ***************************************************************
  // Checks
  // ***************************************************************
  scale_range_a: assert property (@(posedge pclk) disable iff (!presetn)
    scale_num != '0 && scale_den != '0) else $error("scale zero");
  ratio_cap_a: assert property (@(posedge pclk) disable iff (!presetn)
    scale_num <= scale_den) else $error("ratio above one");
  preset_apply_a: assert property (@(posedge pclk) disable iff (!presetn)
    preset_go |-> ##2 position == $past(preset_val, 2))
    else $error("preset not applied");
  preset_range_a: assert property (@(posedge pclk) disable iff (!presetn)
    $signed(preset_val) <= $signed(PRESET_MAX) &&
    $signed(preset_val) >= $signed(neg_max))
    else $error("preset out of range");
  preset_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr && paddr == ADDR_PRESET |=> $stable(zero_shift))
    else $error("shift moved on write");
  preset_err_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr && paddr == ADDR_PRESET && !preset_ok |=>
    stat[ST_PRESET_ERR] && $stable(preset_val))
    else $error("bad preset accepted");
  count_dir_a: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 position == ($past(dir_neg) ? 32'($past(pow2) - 33'($past(sum)))
                                    : $past(sum[31:0])))
    else $error("direction wrong");
  rate_ms_range_a: assert property (@(posedge pclk) disable iff (!presetn)
    rate_ms != '0 && rate_ms <= RATEMS_MAX)
    else $error("rate time out of range");
  rate_refresh_a: assert property (@(posedge pclk) disable iff (!presetn)
    r_start |-> ##49 r_done ##1
    stat[ST_RATE_UPD]) else $error("rate not refreshed");
  invert_a: assert property (@(posedge pclk) disable iff (!presetn)
    raw_valid && logic_neg |=> raw_q == (~$past(raw_data) & bits_mask))
    else $error("data not inverted");

  preset_c: cover property (@(posedge pclk) disable iff (!presetn)
    preset_go && dir_neg);
  rate_c: cover property (@(posedge pclk) disable iff (!presetn)
    r_done && r_neg);
  irq_c: cover property (@(posedge pclk) disable iff (!presetn) irq);
endmodule

//--- design/sps_pkg.sv
// Constants for the position scaling path: register map, limits, timing.
// Assumes a single 125 MHz clock shared by the bus and the data path.
//
// Summary of operation
// - Scale numerator and denominator each hold 1..32767 and reset to one.
// - The numerator never exceeds the denominator, so the ratio is <= 1.
// - A preset command sets the zero shift so the position equals preset.
// - The preset value resets to zero and holds signed +-268435455.
// - Writing the preset value alone changes neither position nor shift.
// - A preset value outside +-268435455 is refused and flags an error.
// - Positive direction passes the value; negative gives 2^n minus it.
// - The exponent n is the programmed data-bit count.
// - The rate update time holds 1..1000 ms and resets to 100 ms.
// - The rate value is refreshed once per rate update interval.
// - Position is raw data times numerator over denominator plus shift.
// - Rate is in the same scaled units as position, per second.
// - Negative data logic inverts the data bits before scaling.
package sps_pkg;

  // ***************************************************************
  // Register map
  // ***************************************************************
  localparam logic [11:0] ADDR_CTRL   = 12'h000;
  localparam logic [11:0] ADDR_NUM    = 12'h004;
  localparam logic [11:0] ADDR_DEN    = 12'h008;
  localparam logic [11:0] ADDR_PRESET = 12'h00C;
  localparam logic [11:0] ADDR_NBITS  = 12'h010;
  localparam logic [11:0] ADDR_RATEMS = 12'h014;
  localparam logic [11:0] ADDR_POS    = 12'h018;
  localparam logic [11:0] ADDR_RATE   = 12'h01C;
  localparam logic [11:0] ADDR_SHIFT  = 12'h020;
  localparam logic [11:0] ADDR_STAT   = 12'h024;
  localparam logic [11:0] ADDR_MASK   = 12'h028;
  localparam logic [11:0] ADDR_RAW    = 12'h02C;

  // ***************************************************************
  // Field positions
  // ***************************************************************
  localparam int CTRL_DIR_NEG   = 0;
  localparam int CTRL_LOGIC_NEG = 1;
  localparam int CTRL_PRESET    = 2;
  localparam int ST_PRESET_ERR  = 0;
  localparam int ST_RATE_UPD    = 1;
  localparam int ST_PARAM_ERR   = 2;
  localparam int ST_PRESET_DONE = 3;
  localparam int ST_W           = 4;

  // ***************************************************************
  // Reset values and limits
  // ***************************************************************
  localparam logic [14:0] SCALE_RST  = 15'h0001;
  localparam logic [14:0] SCALE_MAX  = 15'h7FFF;
  localparam logic [31:0] PRESET_RST = 32'h0000_0000;
  localparam logic [31:0] PRESET_MAX = 32'h0FFF_FFFF;
  localparam logic [5:0]  NBITS_RST  = 6'h18;
  localparam logic [5:0]  NBITS_MAX  = 6'h20;
  localparam logic [9:0]  RATEMS_RST = 10'h064;
  localparam logic [9:0]  RATEMS_MAX = 10'h3E8;

  // ***************************************************************
  // Timing
  // ***************************************************************
  localparam int CLK_KHZ    = 125000;
  localparam int RATE_MS    = 1;
  localparam int MS_CYCLES  = RATE_MS * CLK_KHZ;
  localparam int MS_PER_SEC = 1000;

endpackage

//--- design/sps_div.sv
// Restoring unsigned divider, one quotient bit per clock.
// Assumes start is only raised while busy is low and den is non-zero.
module sps_div
  import sps_pkg::*;
#(
  parameter int NW = 48,
  parameter int DW = 16
) (
  input  wire logic          pclk,
  input  wire logic          presetn,
  input  wire logic          start,
  input  wire logic [NW-1:0] num,
  input  wire logic [DW-1:0] den,
  output logic               busy,
  output logic               done,
  output logic [NW-1:0]      quot
);
  localparam int CW = $clog2(NW + 1);

  logic [DW-1:0] rem;
  logic [DW-1:0] dv;
  logic [CW-1:0] cnt;
  logic [DW:0]   shifted;
  logic          fits;

  assign shifted = {rem, quot[NW-1]};
  assign fits    = shifted >= {1'b0, dv};

  // Remainder never reaches den, so truncation toward zero falls out
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rem  <= '0;
      dv   <= '0;
      quot <= '0;
      cnt  <= '0;
      busy <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start && !busy) begin
        quot <= num;
        rem  <= '0;
        dv   <= den;
        cnt  <= CW'(NW);
        busy <= 1'b1;
      end else if (busy) begin
        rem  <= fits ? DW'(shifted - {1'b0, dv}) : shifted[DW-1:0];
        quot <= {quot[NW-2:0], fits};
        cnt  <= cnt - CW'(1);
        if (cnt == CW'(1)) begin
          busy <= 1'b0;
          done <= 1'b1;
        end
      end
    end
  end

  div_time_a: assert property (@(posedge pclk) disable iff (!presetn)
    start && !busy |-> ##49 done) else $error("divider late");
endmodule

//--- bench/sps_src_model.sv
// Stand-in for the serial receiver that hands raw words to the block.
// Assumes the bench calls push from one process only.
module sps_src_model (
  input  wire logic        pclk,
  output logic      [31:0] raw_data,
  output logic             raw_valid
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    raw_data  = 32'h0000_0000;
    raw_valid = 1'b0;
  end

  // Between strobes the word is inverted, so stale data never matches
  task automatic push(input logic [31:0] v);
    @(posedge pclk);
    raw_data  <= v;
    raw_valid <= 1'b1;
    @(posedge pclk);
    raw_valid <= 1'b0;
    raw_data  <= ~v;
  endtask
endmodule

//--- bench/sps_scaling_tb_top.sv
// Self-checking bench for the position scaling path.
// Assumes the raw source model; the APB master is made by tasks here.
module sps_scaling_tb_top
  import sps_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  // ***************************************************************
  // Signals and instances
  // ***************************************************************
  localparam int MSC = 20;
  logic        pclk, presetn, psel, penable, pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, raw_data, position, rate;
  logic        pready, pslverr, raw_valid, irq, err_v;
  logic [31:0] rd_v, raw_w, e, pv, pos0;
  logic [1:0]  fl;
  logic [11:0] bad_a [7];
  logic [31:0] bad_v [7];
  logic [31:0] bad_k [7];
  int          n_errors, checked, i, nb, nm, dn, p1, p2;
  integer      seed;

  sps_scaling #(.MS_CYC(MSC)) DUT (
    .pclk     (pclk),
    .presetn  (presetn),
    .psel     (psel),
    .penable  (penable),
    .pwrite   (pwrite),
    .paddr    (paddr),
    .pwdata   (pwdata),
    .prdata   (prdata),
    .pready   (pready),
    .pslverr  (pslverr),
    .raw_data (raw_data),
    .raw_valid(raw_valid),
    .position (position),
    .rate     (rate),
    .irq      (irq)
  );

  sps_src_model src (
    .pclk     (pclk),
    .raw_data (raw_data),
    .raw_valid(raw_valid)
  );

  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  // ***************************************************************
  // Tasks and expectations
  // ***************************************************************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd_v = prdata;
    err_v = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rchk(input logic [11:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(rd_v, x);
  endtask

  // Clears the update flag and polls until the next rate refresh
  task automatic wait_rate();
    wr(ADDR_STAT, 32'h2);
    do apb(1'b0, ADDR_STAT, 32'h0); while (rd_v[1] !== 1'b1);
  endtask

  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  function automatic logic [31:0] scl(logic [31:0] r, int b, logic inv,
                                      int m, int d);
    longint unsigned k;
    k = (b == 32) ? 64'hFFFF_FFFF : (64'h1 << b) - 64'h1;
    k = inv ? (~{32'h0, r} & k) : ({32'h0, r} & k);
    return 32'((k * longint'(m)) / longint'(d));
  endfunction

  function automatic logic [31:0] rexp(longint d, longint ms);
    longint a;
    a = (d < 0 ? -d : d) * 1000 / ms;
    return 32'(d < 0 ? -a : a);
  endfunction

  initial begin
    #400000;
    n_errors++;
    final_report();
  end

  // ***************************************************************
  // Main sequence
  // ***************************************************************
  initial begin
    seed = 32'hD66DC77A;
    {presetn, psel, penable, pwrite} = 4'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
    n_errors = 0;
    checked = 0;
    bad_a = '{ADDR_NUM, ADDR_NUM, ADDR_DEN, ADDR_NBITS, ADDR_NBITS,
              ADDR_RATEMS, ADDR_RATEMS};
    bad_v = '{32'h0, 32'h2, 32'h0, 32'h0, 32'h21, 32'h0, 32'h3E9};
    bad_k = '{32'h1, 32'h1, 32'h1, 32'h18, 32'h18, 32'h64, 32'h64};
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    rchk(ADDR_NUM, 32'h1);
    rchk(ADDR_DEN, 32'h1);
    rchk(ADDR_PRESET, 32'h0);
    rchk(ADDR_NBITS, 32'h18);
    rchk(ADDR_RATEMS, 32'h64);
    rchk(ADDR_STAT, 32'h0);
    apb(1'b0, 12'h030, 32'hFFFF_FFFF);
    chk({31'h0, err_v}, 32'h1);
    chk(rd_v, 32'h0);
    for (i = 0; i < 7; i++) begin
      wr(bad_a[i], bad_v[i]);
      rchk(bad_a[i], bad_k[i]);
      rchk(ADDR_STAT, 32'h4);
      wr(ADDR_STAT, 32'h4);
      rchk(ADDR_STAT, 32'h0);
    end
    wr(ADDR_DEN, 32'h7FFF);
    wr(ADDR_NUM, 32'h7FFF);
    rchk(ADDR_NUM, 32'h7FFF);
    wr(ADDR_RATEMS, 32'h3E8);
    rchk(ADDR_RATEMS, 32'h3E8);
    // Ratio pairs are drawn with num <= den
    for (i = 0; i < 10; i++) begin
      nb = (i == 0) ? 32 : (i == 1) ? 1 : 1 + $unsigned($random(seed)) % 32;
      dn = (i == 0) ? 32767 : 1 + $unsigned($random(seed)) % 32767;
      nm = (i == 0) ? 32767 : 1 + $unsigned($random(seed)) % dn;
      fl = 2'($random(seed));
      if (nb == 32) fl[0] = 1'b0;
      raw_w = (i == 0) ? 32'hFFFF_FFFF : $random(seed);
      wr(ADDR_NUM, 32'h1);
      wr(ADDR_DEN, 32'(dn));
      wr(ADDR_NUM, 32'(nm));
      wr(ADDR_NBITS, 32'(nb));
      wr(ADDR_CTRL, {30'h0, fl});
      src.push(raw_w);
      repeat (60) @(posedge pclk);
      e = scl(raw_w, nb, fl[1], nm, dn);
      if (fl[0]) e = 32'((33'h1 << nb) - {1'b0, e});
      chk(position, e);
      rchk(ADDR_POS, e);
      rchk(ADDR_RAW, scl(raw_w, nb, fl[1], 1, 1));
    end
    wr(ADDR_CTRL, 32'h0);
    wr(ADDR_NUM, 32'h1);
    wr(ADDR_DEN, 32'h1);
    wr(ADDR_NBITS, 32'h18);
    wr(ADDR_RATEMS, 32'hA);
    wr(ADDR_MASK, 32'h2);
    p1 = $random(seed) & 32'h0000_FFFF;
    p2 = $random(seed) & 32'h0000_FFFF;
    src.push(32'(p1));
    repeat (3) wait_rate();
    chk({31'h0, irq}, 32'h1);
    chk(rate, 32'h0);
    src.push(32'(p2));
    wait_rate();
    chk(rate, rexp(longint'(p2) - p1, 10));
    src.push(32'(p1));
    wait_rate();
    rchk(ADDR_RATE, rexp(longint'(p1) - p2, 10));
    wr(ADDR_STAT, 32'h2);
    @(negedge pclk);
    chk({31'h0, irq}, 32'h0);
    wr(ADDR_MASK, 32'h0);
    wait_rate();
    @(negedge pclk);
    chk({31'h0, irq}, 32'h0);
    pv = 32'($random(seed) % 268435455);
    pos0 = position;
    wr(ADDR_PRESET, pv);
    rchk(ADDR_PRESET, pv);
    chk(position, pos0);
    rchk(ADDR_SHIFT, 32'h0);
    wr(ADDR_CTRL, 32'h4);
    repeat (4) @(posedge pclk);
    chk(position, pv);
    apb(1'b0, ADDR_STAT, 32'h0);
    chk({31'h0, rd_v[3]}, 32'h1);
    wr(ADDR_PRESET, 32'h0FFF_FFFF);
    wr(ADDR_CTRL, 32'h5);
    repeat (4) @(posedge pclk);
    chk(position, 32'h0FFF_FFFF);
    for (i = 0; i < 2; i++) begin
      wr(ADDR_STAT, 32'hF);
      wr(ADDR_PRESET, (i == 0) ? 32'h1000_0000 : 32'hF000_0000);
      rchk(ADDR_PRESET, 32'h0FFF_FFFF);
      apb(1'b0, ADDR_STAT, 32'h0);
      chk({31'h0, rd_v[0]}, 32'h1);
    end
    // Mid-run reset must bring numerator, preset, rate time and shift back to their defaults
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    chk(position, 32'h0);
    rchk(ADDR_NUM, 32'h1);
    rchk(ADDR_PRESET, 32'h0);
    rchk(ADDR_RATEMS, 32'h64);
    rchk(ADDR_SHIFT, 32'h0);
    final_report();
  end
endmodule
